// File: rtl/usbrr_fifo.sv
module usbrr_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic outValid_q;
  logic push;
  logic pop;
  logic load;

  // head word sits in an output register, so storage holds DEPTH more
  assign inReady = (count_q != DEPTH[AW:0]);
  assign push = inValid && inReady;
  assign load = (count_q != '0) && (!outValid_q || outReady);
  assign pop = load;
  assign outValid = outValid_q;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + AW'(1);
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + AW'(1);
      end
      count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      outValid_q <= 1'b0;
      outData <= '0;
    end else if (load) begin
      outValid_q <= 1'b1;
      outData <= mem[rdPtr_q];
    end else if (outReady) begin
      outValid_q <= 1'b0;
    end
  end

endmodule

// File: rtl/usbrr_pkg.sv
package usbrr_pkg;

  // ******************************************
  // register map
  // ******************************************
  localparam logic [15:0] HS_RESERVE_ADDR = 16'hff14;
  localparam logic [15:0] DATA_RESERVE_ADDR = 16'hff15;
  localparam logic [7:0] HS_RESERVE_RESET = 8'h00;
  localparam logic [3:0] DATA_RESERVE_RESET = 4'h0;
  localparam int DATA_RESERVE_BITS = 4;

  // ******************************************
  // data reservation fields
  // ******************************************
  localparam int EP0_BUF0_BIT = 0;
  localparam int EP1_BUF0_BIT = 1;
  localparam int EP0_BUF1_BIT = 2;
  localparam int EP1_BUF1_BIT = 3;

  // ******************************************
  // handshake reservation fields
  // ******************************************
  localparam int ACK_BIT = 0;
  localparam int DATA_NAK_BIT = 1;
  localparam int EP0_NAK_BIT = 2;
  localparam int EP1_NAK_BIT = 3;
  localparam int DATA_STALL_BIT = 4;
  localparam int LEN_STALL_BIT = 5;
  localparam int EP0_STALL_BIT = 6;
  localparam int EP1_STALL_BIT = 7;

  // ******************************************
  // reply buffer shape
  // ******************************************
  localparam int REPLY_DEPTH = 32;
  localparam int REPLY_WIDTH = 3;

  // access width of a memory manipulation
  typedef enum logic [1:0] {
    ACC_BIT = 2'b00,
    ACC_BYTE = 2'b01,
    ACC_WORD = 2'b10
  } usbrr_acc_t;

  // reply chosen at end of packet
  typedef enum logic [2:0] {
    RPL_EP0_BUF0 = 3'b000,
    RPL_EP0_BUF1 = 3'b001,
    RPL_EP1_BUF0 = 3'b010,
    RPL_EP1_BUF1 = 3'b011,
    RPL_ACK = 3'b100,
    RPL_NAK = 3'b101,
    RPL_STALL = 3'b110
  } usbrr_reply_t;

  typedef struct packed {
    logic setupSeen;
    logic inTokenSeen;
    logic addrMatch;
    logic tokenPidMatch;
    logic ep0TokenSeen;
    logic ep1TokenSeen;
    logic tokenLenErr;
    logic tokenStuffErr;
    logic tokenCrcErr;
  } usbrr_tok_t;

  typedef struct packed {
    logic outTokenSeen;
    logic dataPidMatch;
    logic dataLenErr;
    logic dataStuffErr;
    logic dataCrcErr;
    logic rxWriteErr;
  } usbrr_dat_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wrData;
    logic wrEn;
    logic rdEn;
    usbrr_acc_t size;
    logic [2:0] bitSel;
  } usbrr_mem_t;

endpackage

// File: rtl/usbrr_reply_reserve.sv
// Contract
// - data reservation picks buffer sent after IN
// - data reservation clears on reset, valid SETUP
// - data bits 7..4 zero; bits 3..0 buffers
// - ep0 buffer 0 sent on clean ep0 IN
// - ep0 bank 1 sent, same ep0 conditions
// - ep1 buffer 0 sent, PID match not needed
// - ep1 bank 1 sent, same ep1 conditions
// - bit, byte writes; 16-bit combined word access
// - handshake bits: ACK 0, NAK 1-3, STALL 4-7
// - handshake reservation clears on reset, valid SETUP
// - ep1 stall flag sends STALL on ep1 IN
// - ep0 stall flag sends STALL on ep0 IN
// - length stall on data PID, length error
// - data stall when PID mismatch, no stuffing error
// - ep1 NAK flag sends NAK on ep1 IN
// - ep0 NAK when PID matches, ep0 not seen
// - data NAK on clean OUT data packet
// - ACK on clean matching data packet
module usbrr_reply_reserve
  import usbrr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // memory manipulation port
  input wire usbrr_mem_t mem,
  output logic [15:0] memRdData,
  // receive checker results
  input wire logic tokenEop,
  input wire usbrr_tok_t tokRes,
  input wire logic dataEop,
  input wire usbrr_dat_t datRes,
  // reply toward transmit serializer
  output logic replyValid,
  input wire logic replyReady,
  output usbrr_reply_t replyCode,
  output logic eopReady
);

  // ******************************************
  // register access
  // ******************************************
  logic [7:0] hsRsv_q;
  logic [3:0] dataRsv_q;
  logic [7:0] hsWr;
  logic [7:0] dataWr;
  logic hsHit;
  logic dataHit;
  logic tokClean;
  logic setupValid;

  // a word access at the handshake address covers both registers
  always_comb begin
    hsHit = 1'b0;
    dataHit = 1'b0;
    hsWr = hsRsv_q;
    dataWr = {4'h0, dataRsv_q};
    unique case (mem.size)
      ACC_WORD: begin
        hsHit = (mem.addr == HS_RESERVE_ADDR);
        dataHit = hsHit;
        hsWr = mem.wrData[7:0];
        dataWr = mem.wrData[15:8];
      end
      ACC_BYTE: begin
        hsHit = (mem.addr == HS_RESERVE_ADDR);
        dataHit = (mem.addr == DATA_RESERVE_ADDR);
        hsWr = mem.wrData[7:0];
        dataWr = mem.wrData[7:0];
      end
      ACC_BIT: begin
        hsHit = (mem.addr == HS_RESERVE_ADDR);
        dataHit = (mem.addr == DATA_RESERVE_ADDR);
        hsWr[mem.bitSel] = mem.wrData[0];
        dataWr[mem.bitSel] = mem.wrData[0];
      end
      default: begin
        hsHit = 1'b0;
        dataHit = 1'b0;
      end
    endcase
  end

  assign tokClean = tokRes.inTokenSeen && tokRes.addrMatch
    && !tokRes.tokenLenErr && !tokRes.tokenStuffErr && !tokRes.tokenCrcErr;
  assign setupValid = tokenEop && tokRes.setupSeen && tokRes.addrMatch
    && tokRes.ep0TokenSeen && !tokRes.tokenLenErr
    && !tokRes.tokenStuffErr && !tokRes.tokenCrcErr;

  // setup clear beats a software write in the same cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hsRsv_q <= HS_RESERVE_RESET;
    end else if (setupValid) begin
      hsRsv_q <= HS_RESERVE_RESET;
    end else if (mem.wrEn && hsHit) begin
      hsRsv_q <= hsWr;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dataRsv_q <= DATA_RESERVE_RESET;
    end else if (setupValid) begin
      dataRsv_q <= DATA_RESERVE_RESET;
    end else if (mem.wrEn && dataHit) begin
      dataRsv_q <= dataWr[DATA_RESERVE_BITS-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      memRdData <= 16'h0000;
    end else if (mem.rdEn) begin
      memRdData <= 16'h0000;
      if (mem.size == ACC_WORD && mem.addr == HS_RESERVE_ADDR) begin
        memRdData <= {4'h0, dataRsv_q, hsRsv_q};
      end else if (mem.addr == HS_RESERVE_ADDR) begin
        memRdData <= {8'h00, hsRsv_q};
      end else if (mem.addr == DATA_RESERVE_ADDR) begin
        memRdData <= {12'h000, dataRsv_q};
      end
    end
  end

  // ******************************************
  // reply choice at end of packet
  // ******************************************
  logic ep0Ok;
  logic ep1Ok;
  logic ep0NakOk;
  logic datClean;
  logic pick;
  usbrr_reply_t pickCode;
  logic pushValid_q;
  usbrr_reply_t pushCode_q;
  logic fifoInReady;

  assign ep0Ok = tokClean && tokRes.tokenPidMatch && tokRes.ep0TokenSeen;
  assign ep1Ok = tokClean && tokRes.ep1TokenSeen;
  assign ep0NakOk = tokClean && tokRes.tokenPidMatch && !tokRes.ep0TokenSeen;
  assign datClean = datRes.dataPidMatch && !datRes.dataLenErr
    && !datRes.dataStuffErr && !datRes.dataCrcErr;

  // per endpoint, ep0 before ep1 except the ep0 nak, which comes last: stall first, then buffers, then nak: only one is legal anyway
  always_comb begin
    pick = 1'b0;
    pickCode = RPL_NAK;
    if (tokenEop && !setupValid) begin
      if (ep0Ok && hsRsv_q[EP0_STALL_BIT]) begin
        pick = 1'b1;
        pickCode = RPL_STALL;
      end else if (ep0Ok && dataRsv_q[EP0_BUF0_BIT]) begin
        pick = 1'b1;
        pickCode = RPL_EP0_BUF0;
      end else if (ep0Ok && dataRsv_q[EP0_BUF1_BIT]) begin
        pick = 1'b1;
        pickCode = RPL_EP0_BUF1;
      end else if (ep1Ok && hsRsv_q[EP1_STALL_BIT]) begin
        pick = 1'b1;
        pickCode = RPL_STALL;
      end else if (ep1Ok && dataRsv_q[EP1_BUF0_BIT]) begin
        pick = 1'b1;
        pickCode = RPL_EP1_BUF0;
      end else if (ep1Ok && dataRsv_q[EP1_BUF1_BIT]) begin
        pick = 1'b1;
        pickCode = RPL_EP1_BUF1;
      end else if (ep1Ok && hsRsv_q[EP1_NAK_BIT]) begin
        pick = 1'b1;
        pickCode = RPL_NAK;
      end else if (ep0NakOk && hsRsv_q[EP0_NAK_BIT]) begin
        pick = 1'b1;
        pickCode = RPL_NAK;
      end
    end else if (dataEop && !tokenEop) begin
      // a setup token in the same cycle still wins over the data packet
      if (hsRsv_q[LEN_STALL_BIT] && datRes.dataPidMatch
          && datRes.dataLenErr && !datRes.dataStuffErr) begin
        pick = 1'b1;
        pickCode = RPL_STALL;
      end else if (hsRsv_q[DATA_STALL_BIT] && !datRes.dataPidMatch
          && !datRes.dataStuffErr) begin
        pick = 1'b1;
        pickCode = RPL_STALL;
      end else if (hsRsv_q[DATA_NAK_BIT] && datRes.outTokenSeen
          && datClean && !datRes.rxWriteErr) begin
        pick = 1'b1;
        pickCode = RPL_NAK;
      end else if (hsRsv_q[ACK_BIT] && datClean) begin
        pick = 1'b1;
        pickCode = RPL_ACK;
      end
    end
  end

  // an end of packet while the buffer is full is not answered
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pushValid_q <= 1'b0;
      pushCode_q <= RPL_NAK;
    end else begin
      pushValid_q <= pick && eopReady;
      if (pick) begin
        pushCode_q <= pickCode;
      end
    end
  end

  // no new end of packet accepted while the pipeline register still holds a word
  assign eopReady = fifoInReady && !pushValid_q;

  // ******************************************
  // reply buffer
  // ******************************************
  logic [REPLY_WIDTH-1:0] fifoOut;

  usbrr_fifo #(
    .WIDTH(REPLY_WIDTH),
    .DEPTH(REPLY_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .inValid(pushValid_q),
    .inReady(fifoInReady),
    .inData(pushCode_q),
    .outValid(replyValid),
    .outReady(replyReady),
    .outData(fifoOut)
  );

  assign replyCode = usbrr_reply_t'(fifoOut);

  // ******************************************
  // checks
  // ******************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence ep0InClean;
    tokenEop && !setupValid && eopReady && ep0Ok;
  endsequence

  sequence ep1InClean;
    tokenEop && !setupValid && eopReady && ep1Ok;
  endsequence

  setup_clears_a: assert property (setupValid |=>
    hsRsv_q == 8'h00 && dataRsv_q == 4'h0)
    else $error("reservation not cleared by setup");

  ep0_buf0_a: assert property (ep0InClean ##0
    (hsRsv_q[EP0_STALL_BIT] == 1'b0 && dataRsv_q == 4'h1)
    |=> pushValid_q && pushCode_q == RPL_EP0_BUF0)
    else $error("ep0 buffer 0 reply missing");

  ep1_nopid_a: assert property (ep1InClean ##0
    (!tokRes.tokenPidMatch && hsRsv_q[EP1_STALL_BIT] == 1'b0
    && dataRsv_q == 4'h2) |=> pushCode_q == RPL_EP1_BUF0)
    else $error("ep1 buffer 0 reply needs no pid match");

  ep0_stall_a: assert property (ep0InClean ##0
    hsRsv_q[EP0_STALL_BIT] |=> pushValid_q && pushCode_q == RPL_STALL)
    else $error("ep0 stall reply missing");

  tok_error_a: assert property (tokenEop && !dataEop
    && tokRes.tokenCrcErr |=> !pushValid_q)
    else $error("reply sent after a faulty token");

  len_stall_a: assert property (dataEop && !tokenEop && eopReady
    && hsRsv_q[LEN_STALL_BIT] && datRes.dataPidMatch
    && datRes.dataLenErr && !datRes.dataStuffErr
    |=> pushCode_q == RPL_STALL)
    else $error("length stall reply missing");

  data_ack_a: assert property (dataEop && !tokenEop && eopReady
    && hsRsv_q == 8'h01 && datClean
    |=> pushValid_q && pushCode_q == RPL_ACK ##1 !pushValid_q)
    else $error("ack reply wrong");

  data_nak_a: assert property (dataEop && !tokenEop && eopReady
    && hsRsv_q == 8'h02 && datRes.rxWriteErr |=> !pushValid_q)
    else $error("nak sent despite write error");

  read_zero_a: assert property (mem.rdEn
    && mem.addr == DATA_RESERVE_ADDR |=> memRdData[15:4] == 12'h000)
    else $error("data reservation upper bits not zero");

  ep1_stall_a: assert property (ep1InClean ##0
    (hsRsv_q == 8'h80 && dataRsv_q == 4'h0)
    |=> pushValid_q && pushCode_q == RPL_STALL)
    else $error("ep1 stall reply missing");

  ep0_nak_a: assert property (tokenEop && !setupValid && eopReady
    && ep0NakOk && hsRsv_q == 8'h04 && dataRsv_q == 4'h0
    |=> pushValid_q && pushCode_q == RPL_NAK)
    else $error("ep0 nak reply missing");

  data_stall_a: assert property (dataEop && !tokenEop && eopReady
    && hsRsv_q == 8'h10 && !datRes.dataPidMatch && !datRes.dataStuffErr
    |=> pushValid_q && pushCode_q == RPL_STALL)
    else $error("data stall reply missing");

endmodule

// File: verif/tb_usbrr_reply_reserve.sv
module tb_usbrr_reply_reserve
  import usbrr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

`define CHK(n, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); \
  end \
end

  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  usbrr_mem_t mem = '0;
  logic tokenEop = 1'b0;
  logic dataEop = 1'b0;
  usbrr_tok_t tokRes = '0;
  usbrr_dat_t datRes = '0;
  logic stall = 1'b0;
  logic [15:0] memRdData;
  logic replyValid;
  logic replyReady;
  logic eopReady;
  usbrr_reply_t replyCode;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  int n0;
  logic ok;

  usbrr_reply_reserve u_usbrr_reply_reserve (
    .core_clk(core_clk), .resetn(resetn), .mem(mem),
    .memRdData(memRdData), .tokenEop(tokenEop), .tokRes(tokRes),
    .dataEop(dataEop), .datRes(datRes), .replyValid(replyValid),
    .replyReady(replyReady), .replyCode(replyCode), .eopReady(eopReady)
  );

  usbrr_reply_sink u_usbrr_reply_sink (
    .core_clk(core_clk), .resetn(resetn), .replyValid(replyValid),
    .replyReady(replyReady), .replyCode(replyCode), .stall(stall)
  );

  always #50 core_clk = ~core_clk;

  // ******************************************
  // access and packet tasks
  // ******************************************
  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    input usbrr_acc_t s, input logic [2:0] b);
    @(negedge core_clk);
    mem.addr = a;
    mem.wrData = d;
    mem.size = s;
    mem.bitSel = b;
    mem.wrEn = 1'b1;
    @(negedge core_clk);
    mem.wrEn = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input usbrr_acc_t s,
                    input logic [15:0] e);
    @(negedge core_clk);
    mem.addr = a;
    mem.size = s;
    mem.rdEn = 1'b1;
    @(negedge core_clk);
    mem.rdEn = 1'b0;
    @(negedge core_clk);
    `CHK("memRdData", e, memRdData)
  endtask

  // a full reply buffer holds eopReady low; give up after 8 cycles
  task automatic eop(input logic isData, input logic [8:0] r,
                     output logic acc);
    int w;
    w = 0;
    @(negedge core_clk);
    while (eopReady !== 1'b1 && w < 8) begin
      @(negedge core_clk);
      w++;
    end
    acc = (w < 8);
    if (acc && isData) begin
      dataEop = 1'b1;
      datRes = r[5:0];
    end else if (acc) begin
      tokenEop = 1'b1;
      tokRes = r;
    end
    @(negedge core_clk);
    tokenEop = 1'b0;
    dataEop = 1'b0;
  endtask

  // code 7 means no reply is expected
  task automatic reply(input logic isData, input logic [15:0] word,
                       input logic [8:0] r, input logic [2:0] e);
    int c;
    logic a;
    wr(HS_RESERVE_ADDR, word, ACC_WORD, 3'h0);
    c = u_usbrr_reply_sink.got.size();
    eop(isData, r, a);
    repeat (5) @(negedge core_clk);
    if (e == 3'h7) begin
      `CHK("replyCount", c, u_usbrr_reply_sink.got.size())
    end else begin
      `CHK("replyCount", c + 1, u_usbrr_reply_sink.got.size())
      `CHK("replyCode", e, u_usbrr_reply_sink.got[$])
    end
  endtask

  task print_verdict;
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // generous: the whole sequence needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ******************************************
  // main sequence
  // ******************************************
  initial begin
    repeat (6) @(negedge core_clk);
    resetn = 1'b1;
    rd(HS_RESERVE_ADDR, ACC_BYTE, 16'h0000);
    rd(DATA_RESERVE_ADDR, ACC_BYTE, 16'h0000);
    wr(DATA_RESERVE_ADDR, 16'h00ff, ACC_BYTE, 3'h0);
    rd(DATA_RESERVE_ADDR, ACC_BYTE, 16'h000f);
    wr(HS_RESERVE_ADDR, 16'h0001, ACC_BIT, 3'h7);
    rd(HS_RESERVE_ADDR, ACC_BYTE, 16'h0080);
    wr(DATA_RESERVE_ADDR, 16'h0000, ACC_BIT, 3'h3);
    rd(HS_RESERVE_ADDR, ACC_WORD, 16'h0780);
    rd(16'hff16, ACC_BYTE, 16'h0000);
    // one reservation at a time, as software must, except the last, which sets several before a setup
    reply(1'b0, 16'h0100, 9'h0f0, 3'h0);
    reply(1'b0, 16'h0100, 9'h0f1, 3'h7);
    reply(1'b0, 16'h0400, 9'h0f0, 3'h1);
    reply(1'b0, 16'h0200, 9'h0c8, 3'h2);
    reply(1'b0, 16'h0200, 9'h088, 3'h7);
    reply(1'b0, 16'h0800, 9'h0c8, 3'h3);
    reply(1'b0, 16'h0080, 9'h0c8, 3'h6);
    reply(1'b0, 16'h0040, 9'h0f0, 3'h6);
    reply(1'b1, 16'h0020, 9'h018, 3'h6);
    reply(1'b1, 16'h0010, 9'h000, 3'h6);
    reply(1'b0, 16'h0008, 9'h0c8, 3'h5);
    reply(1'b0, 16'h0004, 9'h0e0, 3'h5);
    reply(1'b1, 16'h0002, 9'h030, 3'h5);
    reply(1'b1, 16'h0002, 9'h031, 3'h7);
    reply(1'b1, 16'h0001, 9'h010, 3'h4);
    reply(1'b1, 16'h0001, 9'h012, 3'h7);
    reply(1'b0, 16'h0f80, 9'h170, 3'h7);
    rd(HS_RESERVE_ADDR, ACC_WORD, 16'h0000);
    // fill the reply buffer while the serializer stalls
    wr(HS_RESERVE_ADDR, 16'h0100, ACC_WORD, 3'h0);
    stall = 1'b1;
    n0 = u_usbrr_reply_sink.got.size();
    n = 0;
    ok = 1'b1;
    while (ok && n < 40) begin
      eop(1'b0, 9'h0f0, ok);
      if (ok) begin
        n++;
      end
    end
    `CHK("acceptedEops", REPLY_DEPTH + 1, n)
    `CHK("replyHeld", 1'b1, replyValid)
    stall = 1'b0;
    repeat (80) @(negedge core_clk);
    `CHK("drained", n0 + n, u_usbrr_reply_sink.got.size())
    `CHK("replyEmpty", 1'b0, replyValid)
    print_verdict();
  end
endmodule

// File: verif/usbrr_reply_sink.sv
module usbrr_reply_sink
  import usbrr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // reply stream
  input wire logic replyValid,
  output logic replyReady,
  input wire usbrr_reply_t replyCode,
  // bench control
  input wire logic stall
);
  timeunit 1ns;
  timeprecision 1ns;

  usbrr_reply_t got[$];

  // ready moves only just after an edge, as a real serializer would
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      replyReady <= 1'b0;
    end else begin
      replyReady <= !stall;
    end
  end

  always @(posedge core_clk) begin
    if (resetn && replyValid && replyReady) begin
      got.push_back(replyCode);
    end
  end
endmodule
